// >>> hw/ethernet_flow_classifier.v
// ethernet flow classifier with axi4-lite register slave
`timescale 1ns/10ps
`default_nettype none
`include "flow_classifier_defines.vh"

module ethernet_flow_classifier #(
    parameter first_comparator = 1
) (
    input wire aclk,
    input wire aresetn,
    input wire [11:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [11:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire hdr_valid,
    input wire [0:0] hdr_channel,
    input wire [47:0] hdr_dst_addr,
    input wire [47:0] hdr_src_addr,
    input wire [1:0] hdr_tag_count,
    input wire [15:0] hdr_tag1_id,
    input wire [11:0] hdr_tag1_vid,
    input wire [15:0] hdr_tag2_id,
    input wire [11:0] hdr_tag2_vid,
    input wire [23:0] hdr_itag_sid,
    input wire [15:0] hdr_len_type,
    input wire hdr_llc_snap,
    output reg match_valid,
    output reg [7:0] match_flags,
    output reg [7:0] match_set_b,
    output reg [0:0] match_channel
);

    // ****************************************
    // storage
    // ****************************************
    // flow words live at index {flow, word}; words 6 and 7 of a flow are holes
    reg [31:0] flow_mem [0:63];
    reg [31:0] global_q;
    reg [7:0] last_flags_q;
    reg [7:0] last_set_b_q;
    reg [11:0] aw_addr_q;
    reg aw_have_q;
    reg [31:0] w_data_q;
    reg [3:0] w_strb_q;
    reg w_have_q;
    integer i;

    // ****************************************
    // helpers
    // ****************************************
    function map_ok;
        input [11:0] a;
        begin
            if (a[`FLOW_REGION_BIT]) begin
                map_ok = (a[11:9] == `FLOW_HIGH_BITS) && (a[4:2] < `FLOW_WORDS) &&
                         (a[1:0] == 2'h0);
            end else begin
                map_ok = (a == `REG_GLOBAL) || (a == `REG_STATUS);
            end
        end
    endfunction

    function [5:0] mem_index;
        input [11:0] a;
        begin
            mem_index = {a[7:5], a[4:2]};
        end
    endfunction

    function [31:0] word_mask;
        input [2:0] w;
        begin
            case (w)
                `WORD_CTRL: word_mask = `MASK_CTRL;
                `WORD_ADDR_LO: word_mask = `MASK_ADDR_LO;
                `WORD_ADDR_HI: word_mask = `MASK_ADDR_HI;
                default: word_mask = `MASK_PAIR12;
            endcase
        end
    endfunction

    function [31:0] merge;
        input [31:0] old;
        input [31:0] data;
        input [3:0] strb;
        integer b;
        begin
            merge = old;
            for (b = 0; b < 4; b = b + 1) begin
                if (strb[b]) begin
                    merge[b*8 +: 8] = data[b*8 +: 8];
                end
            end
        end
    endfunction

    // group bit is the lsb of the first octet on the wire, held in bit 40 here
    function addr_hit;
        input [47:0] frame_addr;
        input [47:0] stored;
        input [2:0] kinds;
        begin
            addr_hit = (kinds[`KIND_EXACT] && (frame_addr == stored)) ||
                       (kinds[`KIND_UCAST] && !frame_addr[`GROUP_BIT]) ||
                       (kinds[`KIND_MCAST] && frame_addr[`GROUP_BIT]);
        end
    endfunction

    function masked_eq;
        input [11:0] vid;
        input [11:0] value;
        input [11:0] mask;
        begin
            masked_eq = ((vid ^ value) & mask) == 12'h000;
        end
    endfunction

    // ****************************************
    // axi4-lite write channel
    // ****************************************
    wire wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
    wire [5:0] wr_idx = mem_index(aw_addr_q);

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_addr_q <= 12'h000;
            w_data_q <= `RESET_WORD;
            w_strb_q <= 4'h0;
            global_q <= `RESET_WORD;
            for (i = 0; i < 64; i = i + 1) begin
                flow_mem[i] <= `RESET_WORD;
            end
        end else begin
            // ready only while the holding slot is empty and no answer waits
            s_axi_awready <= !aw_have_q && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
            s_axi_wready <= !w_have_q && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= map_ok(aw_addr_q) ? `RESP_OKAY : `RESP_SLVERR;
                if (map_ok(aw_addr_q)) begin
                    if (aw_addr_q[`FLOW_REGION_BIT]) begin
                        flow_mem[wr_idx] <= merge(flow_mem[wr_idx], w_data_q, w_strb_q) &
                                            word_mask(aw_addr_q[4:2]);
                    end else if (aw_addr_q == `REG_GLOBAL) begin
                        global_q <= merge(global_q, w_data_q, w_strb_q) & `MASK_GLOBAL;
                    end
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ****************************************
    // axi4-lite read channel
    // ****************************************
    // bridging bit reads zero in the second comparator, where it does not exist
    wire bridging = (first_comparator != 0) && global_q[`GLB_BRIDGE];
    wire [15:0] service_id = global_q[`GLB_TAG_ID_LSB +: 16];

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= `RESET_WORD;
            s_axi_rresp <= `RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= map_ok(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
                if (!map_ok(s_axi_araddr)) begin
                    s_axi_rdata <= `RESET_WORD;
                end else if (s_axi_araddr[`FLOW_REGION_BIT]) begin
                    s_axi_rdata <= flow_mem[mem_index(s_axi_araddr)];
                end else if (s_axi_araddr == `REG_GLOBAL) begin
                    s_axi_rdata <= {15'h0000, bridging, service_id};
                end else begin
                    s_axi_rdata <= {16'h0000, last_set_b_q, last_flags_q};
                end
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ****************************************
    // per-flow classification
    // ****************************************
    reg [7:0] hit;
    reg [7:0] set_b;
    reg [31:0] ctl;
    reg [47:0] st_addr;
    reg [11:0] t1_val, t1_mask, t2_val, t2_mask, r_low, r_high;
    reg [1:0] cnt, rsel, which;
    reg [2:0] kinds;
    reg consider, tags_ok, ftype_ok, addr_ok, sid_ok, verify;
    integer f;

    always @* begin
        hit = 8'h00;
        set_b = 8'h00;
        ctl = `RESET_WORD;
        st_addr = 48'h000000000000;
        t1_val = 12'h000;
        t1_mask = 12'h000;
        t2_val = 12'h000;
        t2_mask = 12'h000;
        r_low = 12'h000;
        r_high = 12'h000;
        cnt = 2'h0;
        rsel = 2'h0;
        which = 2'h0;
        kinds = 3'h0;
        consider = 1'b0;
        tags_ok = 1'b0;
        ftype_ok = 1'b0;
        addr_ok = 1'b0;
        sid_ok = 1'b0;
        verify = 1'b0;
        for (f = 0; f < `FLOWS; f = f + 1) begin
            ctl = flow_mem[f*8 + 0];
            st_addr = {flow_mem[f*8 + 2][15:0], flow_mem[f*8 + 1]};
            t1_val = flow_mem[f*8 + 3][`LO12_LSB +: 12];
            t1_mask = flow_mem[f*8 + 3][`HI12_LSB +: 12];
            t2_val = flow_mem[f*8 + 4][`LO12_LSB +: 12];
            t2_mask = flow_mem[f*8 + 4][`HI12_LSB +: 12];
            r_low = flow_mem[f*8 + 5][`LO12_LSB +: 12];
            r_high = flow_mem[f*8 + 5][`HI12_LSB +: 12];
            cnt = ctl[`CTL_COUNT_LSB +: 2];
            rsel = ctl[`CTL_RANGE_LSB +: 2];
            which = ctl[`CTL_WHICH_LSB +: 2];
            kinds = ctl[`CTL_KINDS_LSB +: 3];
            verify = ctl[`CTL_VERIFY];
            consider = ctl[`CTL_ENABLE] && ctl[`CTL_USE_LSB + hdr_channel];
            sid_ok = hdr_itag_sid == {r_high, r_low};
            if (bridging) begin
                if (!ctl[`CTL_TYPE1]) begin
                    // outer tag plus i-tag, always two; second type bit unused
                    tags_ok = (hdr_tag_count == 2'h2) && (hdr_tag2_id == `ITAG_ID) &&
                              sid_ok;
                    if (verify) begin
                        tags_ok = tags_ok && (hdr_tag1_id == service_id) &&
                                  masked_eq(hdr_tag1_vid, t1_val, t1_mask);
                    end
                end else begin
                    tags_ok = (hdr_tag_count != 2'h0) && (hdr_tag1_id == `ITAG_ID) &&
                              sid_ok;
                    if (verify) begin
                        tags_ok = tags_ok && (hdr_tag_count == cnt);
                    end
                end
            end else if (!verify) begin
                tags_ok = 1'b1;
            end else begin
                tags_ok = (hdr_tag_count == cnt);
                if (cnt != 2'h0) begin
                    tags_ok = tags_ok && masked_eq(hdr_tag1_vid, t1_val, t1_mask) &&
                              (hdr_tag1_id == (ctl[`CTL_TYPE1] ? service_id :
                                               `CUSTOMER_TAG_ID));
                end
                if (cnt == 2'h2) begin
                    tags_ok = tags_ok && masked_eq(hdr_tag2_vid, t2_val, t2_mask) &&
                              (hdr_tag2_id == (ctl[`CTL_TYPE2] ? service_id :
                                               `CUSTOMER_TAG_ID));
                end
                // inclusive range on the chosen tag
                if (rsel == `RANGE_TAG1) begin
                    tags_ok = tags_ok && (hdr_tag1_vid >= r_low) &&
                              (hdr_tag1_vid <= r_high);
                end else if (rsel == `RANGE_TAG2) begin
                    tags_ok = tags_ok && (hdr_tag2_vid >= r_low) &&
                              (hdr_tag2_vid <= r_high);
                end
            end
            if (!ctl[`CTL_FTYPE]) begin
                ftype_ok = (hdr_len_type >= `LENGTH_LIMIT) && !hdr_llc_snap;
            end else if (hdr_len_type < `LENGTH_LIMIT) begin
                ftype_ok = hdr_llc_snap;
            end else begin
                ftype_ok = !hdr_llc_snap;
            end
            // reserved selector value never matches
            case (which)
                `WHICH_DST: addr_ok = addr_hit(hdr_dst_addr, st_addr, kinds);
                `WHICH_SRC: addr_ok = addr_hit(hdr_src_addr, st_addr, kinds);
                `WHICH_EITHER: addr_ok = addr_hit(hdr_dst_addr, st_addr, kinds) ||
                                         addr_hit(hdr_src_addr, st_addr, kinds);
                default: addr_ok = 1'b0;
            endcase
            hit[f] = consider && tags_ok && ftype_ok && addr_ok;
            set_b[f] = ctl[`CTL_SET_B];
        end
    end

    // ****************************************
    // result registers
    // ****************************************
    always @(posedge aclk) begin
        if (!aresetn) begin
            match_valid <= 1'b0;
            match_flags <= 8'h00;
            match_set_b <= 8'h00;
            match_channel <= 1'b0;
            last_flags_q <= 8'h00;
            last_set_b_q <= 8'h00;
        end else begin
            match_valid <= hdr_valid;
            if (hdr_valid) begin
                match_flags <= hit;
                match_set_b <= set_b & hit;
                match_channel <= hdr_channel;
                last_flags_q <= hit;
                last_set_b_q <= set_b & hit;
            end
        end
    end

endmodule // ethernet_flow_classifier

`default_nettype wire

// >>> inc/flow_classifier_defines.vh
// constants for the ethernet flow classifier stage
`ifndef FLOW_CLASSIFIER_DEFINES_VH
`define FLOW_CLASSIFIER_DEFINES_VH

// ****************************************
// sizes
// ****************************************
`define FLOWS 8
`define CHANNELS 2
`define FLOW_IDX_W 3
`define WORD_IDX_W 3
`define FLOW_WORDS 6

// ****************************************
// register map (byte addresses)
// ****************************************
`define ADDR_W 12
`define REG_GLOBAL 12'h000
`define REG_STATUS 12'h004
`define FLOW_REGION_BIT 8
`define FLOW_HIGH_BITS 3'h0
`define FLOW_SEL_LSB 5
`define WORD_SEL_LSB 2
`define WORD_CTRL 3'h0
`define WORD_ADDR_LO 3'h1
`define WORD_ADDR_HI 3'h2
`define WORD_TAG1 3'h3
`define WORD_TAG2 3'h4
`define WORD_RANGE 3'h5

// ****************************************
// read masks (reserved bits read zero)
// ****************************************
`define MASK_CTRL 32'h0001ffff
`define MASK_ADDR_LO 32'hffffffff
`define MASK_ADDR_HI 32'h0000ffff
`define MASK_PAIR12 32'h0fff0fff
`define MASK_GLOBAL 32'h0001ffff
`define RESET_WORD 32'h00000000

// ****************************************
// control word fields
// ****************************************
`define CTL_ENABLE 0
`define CTL_USE_LSB 1
`define CTL_COUNT_LSB 3
`define CTL_TYPE1 5
`define CTL_TYPE2 6
`define CTL_FTYPE 7
`define CTL_VERIFY 8
`define CTL_RANGE_LSB 9
`define CTL_WHICH_LSB 11
`define CTL_KINDS_LSB 13
`define CTL_SET_B 16
`define LO12_LSB 0
`define HI12_LSB 16
`define GLB_TAG_ID_LSB 0
`define GLB_BRIDGE 16

// ****************************************
// encodings and frame constants
// ****************************************
`define CUSTOMER_TAG_ID 16'h8100
`define ITAG_ID 16'h88e7
`define LENGTH_LIMIT 16'h0600
`define GROUP_BIT 40
`define RANGE_NONE 2'h0
`define RANGE_TAG1 2'h1
`define RANGE_TAG2 2'h2
`define WHICH_DST 2'h0
`define WHICH_SRC 2'h1
`define WHICH_EITHER 2'h2
`define KIND_EXACT 0
`define KIND_UCAST 1
`define KIND_MCAST 2
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// >>> testbench/ethernet_flow_classifier_bench.sv
// self-checking bench for the ethernet flow classifier
`timescale 1ns/10ps
`default_nettype none
`include "flow_classifier_defines.vh"
module ethernet_flow_classifier_bench;
// ****************************************
// stimulus and checking
// ****************************************
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata;
    logic [3:0] s_axi_wstrb;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, match_valid;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [7:0] match_flags, match_set_b;
    wire [0:0] match_channel, hdr_channel;
    wire hdr_valid, hdr_llc_snap;
    wire [47:0] hdr_dst_addr, hdr_src_addr;
    wire [1:0] hdr_tag_count;
    wire [15:0] hdr_tag1_id, hdr_tag2_id, hdr_len_type;
    wire [11:0] hdr_tag1_vid, hdr_tag2_vid;
    wire [23:0] hdr_itag_sid;
    logic [0:0] ch;
    logic [47:0] da, sa;
    logic [1:0] cnt;
    logic [15:0] i1, i2, lt;
    logic [11:0] v1, v2;
    logic [23:0] sid;
    logic llc;
    int fails = 0;
    int check_count = 0;
    ethernet_flow_classifier #(.first_comparator(1)) u_dut (.*);
    header_source u_src (.*);
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic summarize;
        $display("comparisons %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic stall;
        fails++;
        summarize();
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d,
        input logic [1:0] r = `RESP_OKAY);
        int n;
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} <= {a, d, 2'b11};
        for (n = 0; n < 40 && !s_axi_bvalid; n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end
        if (n == 40) stall();
        // ready comes late on purpose so the response has to stand
        s_axi_bready <= 1'b1;
        @(posedge aclk);
        check(s_axi_bresp, r);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] d,
        input logic [1:0] r = `RESP_OKAY);
        int n;
        @(posedge aclk);
        {s_axi_araddr, s_axi_arvalid} <= {a, 1'b1};
        for (n = 0; n < 40 && !s_axi_rvalid; n++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        if (n == 40) stall();
        s_axi_rready <= 1'b1;
        @(posedge aclk);
        check(s_axi_rdata, d);
        check(s_axi_rresp, r);
        s_axi_rready <= 1'b0;
    endtask
    task automatic dflt;
        {ch, cnt, i1, v1, i2, v2, sid, llc} = '0;
        {da, sa, lt} = {48'h021122334455, 48'h0100aabbccdd, 16'h0800};
    endtask
    task automatic hit(input logic [7:0] e);
        u_src.send(ch, da, sa, cnt, i1, v1, i2, v2, sid, lt, llc);
        #1;
        check(match_valid, 1'b1);
        check(match_flags, e);
        check(match_channel, ch);
    endtask
    task automatic flow(input logic [2:0] f, input logic [31:0] c, t1, t2, rg);
        logic [11:0] b;
        b = 12'h100 + {4'h0, f, 5'h00};
        wr(b, c);
        wr(b + 12'h004, 32'h22334455);
        wr(b + 12'h008, 32'h00000211);
        wr(b + 12'h00c, t1);
        wr(b + 12'h010, t2);
        wr(b + 12'h014, rg);
    endtask
    task automatic regs_scn;
        rd(`REG_GLOBAL, `RESET_WORD);
        rd(`REG_STATUS, `RESET_WORD);
        rd(12'h100, `RESET_WORD);
        wr(12'h100, 32'hffffffff);
        rd(12'h100, `MASK_CTRL);
        // only byte one is enabled, the other bytes must keep their value
        s_axi_wstrb <= 4'h2;
        wr(12'h100, 32'h00000000);
        s_axi_wstrb <= 4'hf;
        rd(12'h100, 32'h000100ff);
        wr(12'h110, 32'hffffffff);
        rd(12'h110, `MASK_PAIR12);
        wr(12'h118, 32'h00000001, `RESP_SLVERR);
        rd(12'h11c, 32'h00000000, `RESP_SLVERR);
    endtask
    task automatic chan_scn;
        dflt();
        flow(3'h0, 32'h00002003, 32'h0, 32'h0, 32'h0);
        hit(8'h01);
        ch = 1'b1;
        hit(8'h00);
        wr(12'h100, 32'h00002005);
        hit(8'h01);
        wr(12'h100, 32'h00002004);
        hit(8'h00);
    endtask
    task automatic addr_scn;
        // entry 7 uses the reserved selector, entries 3 and 10 the exact kind
        logic [4:0] t [11] = '{5'h01, 5'h09, 5'h0c, 5'h04, 5'h11, 5'h12, 5'h19, 5'h1b, 5'h02,
            5'h0a, 5'h04};
        logic [10:0] e = 11'b11001110100;
        dflt();
        for (int i = 0; i < 11; i++) begin
            da[0] = (i == 10);
            wr(12'h100, 32'h00000003 | {16'h0000, t[i], 11'h000});
            hit({7'h00, e[i]});
        end
    endtask
    task automatic tag_scn;
        dflt();
        wr(`REG_GLOBAL, 32'h000088a8);
        flow(3'h0, 32'h00002133, 32'h0fff0123, 32'h0ff00450, 32'h0);
        {cnt, i1, v1, i2, v2} = {2'h2, 16'h88a8, 12'h123, `CUSTOMER_TAG_ID, 12'h45f};
        hit(8'h01);
        i1 = `CUSTOMER_TAG_ID;
        hit(8'h00);
        {i1, v2} = {16'h88a8, 12'h46f};
        hit(8'h00);
        {cnt, v2} = {2'h1, 12'h45f};
        hit(8'h00);
        cnt = 2'h2;
        wr(12'h100, 32'h00002173);
        hit(8'h00);
        i2 = 16'h88a8;
        hit(8'h01);
        wr(12'h100, 32'h00002073);
        {i1, v1} = {`CUSTOMER_TAG_ID, 12'h000};
        hit(8'h01);
    endtask
    task automatic range_scn;
        logic [11:0] v [4] = '{12'h0ff, 12'h100, 12'h200, 12'h201};
        dflt();
        flow(3'h0, 32'h00002113, 32'h0, 32'h0, 32'h02000100);
        {cnt, i1, v1, i2, v2} = {2'h2, `CUSTOMER_TAG_ID, 12'h050, `CUSTOMER_TAG_ID, 12'h050};
        hit(8'h01);
        for (int m = 1; m < 3; m++) begin
            wr(12'h100, 32'h00002113 | (m << 9));
            for (int k = 0; k < 4; k++) begin
                v1 = (m == 1) ? v[k] : 12'h050;
                v2 = (m == 2) ? v[k] : 12'h050;
                hit({7'h00, k == 1 || k == 2});
            end
        end
    endtask
    task automatic ftype_scn;
        logic [15:0] l [7] = '{16'h0800, 16'h0800, 16'h05ff, 16'h05ff, 16'h05ff, `LENGTH_LIMIT,
            `LENGTH_LIMIT};
        logic [6:0] s = 7'b1001010;
        logic [6:0] e = 7'b0101001;
        dflt();
        for (int i = 0; i < 7; i++) begin
            if (i == 0 || i == 3) wr(12'h100, (i == 0) ? 32'h00002003 : 32'h00002083);
            {lt, llc} = {l[i], s[i]};
            hit({7'h00, e[i]});
        end
    endtask
    task automatic bridge_scn;
        dflt();
        wr(`REG_GLOBAL, 32'h000188a8);
        rd(`REG_GLOBAL, 32'h000188a8);
        flow(3'h0, 32'h00002013, 32'h0, 32'h0, 32'h0abc0def);
        {cnt, i1, i2, sid} = {2'h2, 16'h88a8, `ITAG_ID, 24'habcdef};
        hit(8'h01);
        sid = 24'habcdee;
        hit(8'h00);
        wr(12'h100, 32'h00002023);
        {cnt, i1, sid} = {2'h1, `ITAG_ID, 24'habcdef};
        hit(8'h01);
        i1 = `CUSTOMER_TAG_ID;
        hit(8'h00);
        wr(`REG_GLOBAL, 32'h000088a8);
    endtask
    task automatic setb_scn;
        dflt();
        // tag masks left at zero on every flow that does not look at tags
        for (int f = 0; f < 8; f++) flow(f[2:0], 32'h00004003 | ((f % 2) << 16), 0, 0, 0);
        hit(8'hff);
        check(match_set_b, 8'haa);
        rd(`REG_STATUS, 32'h0000aaff);
        ch = 1'b1;
        hit(8'h00);
        check(match_set_b, 8'h00);
    endtask
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {24'h000000, 32'h0, 4'hf};
        dflt();
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        regs_scn();
        chan_scn();
        addr_scn();
        tag_scn();
        range_scn();
        ftype_scn();
        bridge_scn();
        setb_scn();
        summarize();
    end
endmodule // ethernet_flow_classifier_bench
bind ethernet_flow_classifier flow_checker u_chk (.*);
`default_nettype wire

// >>> testbench/flow_checker_sva.sv
// port checker for the ethernet flow classifier
`timescale 1ns/10ps
`default_nettype none
module flow_checker (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic hdr_valid,
    input wire logic [0:0] hdr_channel,
    input wire logic match_valid,
    input wire logic [7:0] match_flags,
    input wire logic [7:0] match_set_b,
    input wire logic [0:0] match_channel
);
// ****************************************
// properties
// ****************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    write_answer_a: assert property (wr_taken |=> ##1 s_axi_bvalid)
        else $error("write response missing");
    write_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
    read_answer_a: assert property (rd_taken |=> s_axi_rvalid)
        else $error("read response missing");
    read_hold_a: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted while answer pending");
    match_pulse_a: assert property (
        hdr_valid |=> match_valid && match_channel == $past(hdr_channel))
        else $error("match result missing or wrong channel");
    match_quiet_a: assert property (
        !hdr_valid |=> !match_valid && $stable(match_flags))
        else $error("match result without header");
    set_b_only_a: assert property ((match_set_b & ~match_flags) == 8'h00)
        else $error("set b flag on unmatched flow");
endmodule // flow_checker
`default_nettype wire

// >>> testbench/header_source.sv
// behavioural header parser feeding the classifier
`timescale 1ns/10ps
`default_nettype none
module header_source (
    input wire logic aclk,
    output logic hdr_valid,
    output logic [0:0] hdr_channel,
    output logic [47:0] hdr_dst_addr,
    output logic [47:0] hdr_src_addr,
    output logic [1:0] hdr_tag_count,
    output logic [15:0] hdr_tag1_id,
    output logic [11:0] hdr_tag1_vid,
    output logic [15:0] hdr_tag2_id,
    output logic [11:0] hdr_tag2_vid,
    output logic [23:0] hdr_itag_sid,
    output logic [15:0] hdr_len_type,
    output logic hdr_llc_snap
);
// ****************************************
// header drive
// ****************************************
    logic [195:0] word;
    assign {hdr_channel, hdr_dst_addr, hdr_src_addr, hdr_tag_count, hdr_tag1_id, hdr_tag1_vid,
        hdr_tag2_id, hdr_tag2_vid, hdr_itag_sid, hdr_len_type, hdr_llc_snap} = word;
    initial begin
        hdr_valid = 1'b0;
        word = '0;
    end
    task automatic send(input logic [0:0] ch, input logic [47:0] da, sa, input logic [1:0] cnt,
        input logic [15:0] i1, input logic [11:0] v1, input logic [15:0] i2,
        input logic [11:0] v2, input logic [23:0] sid, input logic [15:0] lt, input logic llc);
        @(posedge aclk);
        hdr_valid <= 1'b1;
        word <= {ch, da, sa, cnt, i1, v1, i2, v2, sid, lt, llc};
        @(posedge aclk);
        hdr_valid <= 1'b0;
        // fields are stale outside the valid cycle: invert so nothing leans on them
        word <= ~word;
    endtask
endmodule // header_source
`default_nettype wire
